//--- common/adc_serial_pkg.sv
// shared constants and types for the converter serial result port
package adc_serial_pkg;
   // result word
   localparam int RESULT_WIDTH = 16;
   // clock and serial timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCLK_HALF_NS = 50;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_CNT_W = 8;
   localparam int DIV_SEL_W = 2;
   // pin positions of the serial functions on the result bus
   localparam int PIN_SER_OUT = 8;
   localparam int PIN_SCLK = 9;
   localparam int PIN_SYNC = 10;
   localparam int PIN_RD_FLAG = 11;
   // configuration pins, used as config inputs in serial mode
   localparam int PIN_CFG_LO = 2;
   localparam int PIN_CFG_HI = 7;

   // serial configuration, sampled from the shared pins
   typedef struct packed {
      logic clockSourceSelect;
      logic [DIV_SEL_W-1:0] serialClockDivider;
      logic frameSyncPolarity;
      logic serialClockInvert;
      logic readModeOrChainIn;
   } serial_cfg_t;

   // master shifter states
   typedef enum logic {M_IDLE, M_SHIFT} master_state_t;
endpackage

//--- logic/sclk_divider.sv
// serial clock half-period tick generator with power-of-two slowdown
`timescale 1ns/1ps
module sclk_divider
   import adc_serial_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic [DIV_SEL_W-1:0] divSel,
   // one-cycle enable per serial clock half period
   output logic tick
);
   logic [DIV_CNT_W-1:0] cnt_reg;
   logic [DIV_CNT_W-1:0] cnt_next;
   wire [DIV_CNT_W-1:0] limit =
      DIV_CNT_W'((HALF_CYC << divSel) - 1);

   assign tick = run && (cnt_reg == limit);
   assign cnt_next = (!run || tick) ? '0 : cnt_reg + 1'b1;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

//--- logic/adc_serial_port_config.sv
// result port of the converter: parallel bus or master/slave serial port
`timescale 1ns/1ps

// How it works
// - divider slows master clock only in read-after-convert
// - master mode drives internal clock on clock pin
// - slave shifts on host clock gated by select
// - sync active high unless polarity input high
// - clock invert honoured in master and slave
// - chain input reaches data out after 16 clocks
// - master read-during-convert sends previous result
// - master read-after-convert sends after conversion completes
// - parallel mode drives shared pins as bits 2-7
// - select low is parallel, high is serial
// - slave updates data on rising clock edge
// - master sync held active while data valid
// - slave unfinished read at conversion end flags error
module adc_serial_port_config
   import adc_serial_pkg::*;
#(
   parameter int RESULT_W = RESULT_WIDTH
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // converter core
   input wire logic convStart,
   input wire logic convDone,
   input wire logic [RESULT_W-1:0] convResult,
   // port configuration pins
   input wire logic portStyleSelect,
   input wire serial_cfg_t serialCfg,
   // host serial clock and converter select
   input wire logic sclkIn,
   input wire logic csAdcN,
   // result pins, with drive enables
   output logic [RESULT_W-1:0] pinOut,
   output logic [RESULT_W-1:0] pinOe,
   // status
   output logic incompleteReadFlag
);
   localparam int HALF_A = SCLK_HALF_CYC;
   localparam logic [4:0] LAST_BIT = 5'(RESULT_W - 1);
   localparam logic [4:0] FULL_CNT = 5'(RESULT_W);

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   wire serialMode = portStyleSelect;
   wire master = serialMode && !serialCfg.clockSourceSelect;
   wire slave = serialMode && serialCfg.clockSourceSelect;
   wire readDuring = serialCfg.readModeOrChainIn;
   // divider inputs are meaningless in the other serial modes
   wire useDiv = master && !readDuring;
   wire [DIV_SEL_W-1:0] divSel =
      useDiv ? serialCfg.serialClockDivider : '0;

   ////////////////////////////////////////////////////////////////////////
   // state
   master_state_t state_reg, state_next;
   logic [RESULT_W-1:0] lastResult_reg;
   logic [RESULT_W-1:0] shift_reg, shift_next;
   logic [4:0] bitCnt_reg, bitCnt_next;
   logic mPhase_reg, mPhase_next;
   logic effPrev_reg;
   logic csPrevN_reg;
   logic readActive_reg, readActive_next;
   logic rdErr_reg, rdErr_next;
   logic [RESULT_W-1:0] pinOut_next, pinOe_next;
   logic tick;

   wire shifting = (state_reg == M_SHIFT);

   sclk_divider #(.HALF_CYC(SCLK_HALF_CYC)) divider (
      .clk(clk),
      .rst(rst),
      .run(shifting),
      .divSel(divSel),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // master triggers and edges
   wire mTrigger = master && !shifting &&
      (readDuring ? convStart : convDone);
   // previous word while converting, fresh word after completion
   wire [RESULT_W-1:0] mLoad =
      readDuring ? lastResult_reg : convResult;
   wire mFall = shifting && tick && mPhase_reg;
   wire mLast = mFall && (bitCnt_reg == LAST_BIT);

   ////////////////////////////////////////////////////////////////////////
   // slave edges: host clock taken as synchronous to clk
   wire effClk = sclkIn ^ serialCfg.serialClockInvert;
   wire sRise = slave && !csAdcN && effClk && !effPrev_reg;
   wire csFall = slave && !csAdcN && csPrevN_reg;
   wire sLost = slave && readActive_reg && convDone;

   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      bitCnt_next = bitCnt_reg;
      mPhase_next = mPhase_reg;
      readActive_next = readActive_reg;
      rdErr_next = 1'b0;
      if (master) begin
         if (mTrigger) begin
            state_next = M_SHIFT;
            shift_next = mLoad;
            bitCnt_next = '0;
            mPhase_next = 1'b0;
         end else if (shifting && tick) begin
            mPhase_next = !mPhase_reg;
            if (mFall) begin
               shift_next = {shift_reg[RESULT_W-2:0], 1'b0};
               bitCnt_next = bitCnt_reg + 5'h01;
            end
            if (mLast) begin
               state_next = M_IDLE;
            end
         end
      end else begin
         state_next = M_IDLE;
         mPhase_next = 1'b0;
         if (sLost) begin
            // unfinished word is dropped for the new one
            rdErr_next = 1'b1;
            shift_next = convResult;
            bitCnt_next = '0;
         end else if (convDone && !readActive_reg) begin
            shift_next = convResult;
         end else if (sRise) begin
            // chain bit enters at the bottom, leaves 16 clocks on
            shift_next = {shift_reg[RESULT_W-2:0],
               serialCfg.readModeOrChainIn};
            bitCnt_next = bitCnt_reg + 5'h01;
         end
         if (csFall) begin
            readActive_next = 1'b1;
            bitCnt_next = '0;
         end else if (csAdcN || bitCnt_next == FULL_CNT) begin
            readActive_next = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive
   wire mSclk = (shifting && mPhase_reg) ^
      serialCfg.serialClockInvert;
   wire mSync = shifting ^ serialCfg.frameSyncPolarity;

   always_comb begin
      pinOut_next = '0;
      pinOe_next = '0;
      if (!serialMode) begin
         // whole bus drives, shared config pins included
         pinOut_next = lastResult_reg;
         pinOe_next = '1;
      end else begin
         pinOut_next[PIN_SER_OUT] = shift_reg[RESULT_W-1];
         pinOe_next[PIN_SER_OUT] = 1'b1;
         pinOut_next[PIN_SCLK] = mSclk;
         pinOe_next[PIN_SCLK] = master;
         pinOut_next[PIN_SYNC] = mSync;
         pinOe_next[PIN_SYNC] = master;
         pinOut_next[PIN_RD_FLAG] = rdErr_next;
         pinOe_next[PIN_RD_FLAG] = slave;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= M_IDLE;
         shift_reg <= '0;
         bitCnt_reg <= '0;
         mPhase_reg <= 1'b0;
         readActive_reg <= 1'b0;
         rdErr_reg <= 1'b0;
         pinOut <= '0;
         pinOe <= '0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bitCnt_reg <= bitCnt_next;
         mPhase_reg <= mPhase_next;
         readActive_reg <= readActive_next;
         rdErr_reg <= rdErr_next;
         pinOut <= pinOut_next;
         pinOe <= pinOe_next;
      end
   end

   // last result and edge history; host-side inputs held idle at reset
   always_ff @(posedge clk) begin
      if (rst) begin
         lastResult_reg <= '0;
         effPrev_reg <= 1'b0;
         csPrevN_reg <= 1'b1;
      end else begin
         if (convDone) begin
            lastResult_reg <= convResult;
         end
         effPrev_reg <= effClk;
         csPrevN_reg <= csAdcN;
      end
   end

   assign incompleteReadFlag = rdErr_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_div_half_period: assert property (
      (shifting && tick && !mPhase_reg && !useDiv && master)
      |-> ##HALF_A tick)
      else $error("undivided master clock half period wrong");
   a_master_clock_out: assert property (
      (master && shifting) |=> pinOe[PIN_SCLK])
      else $error("master clock not driven");
   a_slave_gate: assert property (
      (slave && csAdcN && !convDone) |=> $stable(shift_reg))
      else $error("slave shifted while deselected");
   a_sync_level: assert property (
      (master && shifting) |=>
      pinOut[PIN_SYNC] == !$past(serialCfg.frameSyncPolarity))
      else $error("frame sync at wrong level");
   a_clock_invert: assert property (
      (master && !shifting) |=>
      pinOut[PIN_SCLK] == $past(serialCfg.serialClockInvert))
      else $error("idle clock ignores invert");
   a_chain_entry: assert property (
      (sRise && !sLost && !(convDone && !readActive_reg)) |=>
      shift_reg[0] == $past(serialCfg.readModeOrChainIn))
      else $error("chain bit not taken");
   a_read_during: assert property (
      (master && readDuring && convStart && !shifting) |=>
      shifting && shift_reg == $past(lastResult_reg))
      else $error("read during convert not started");
   a_read_after: assert property (
      (master && !readDuring && !shifting && !convDone) |=> !shifting)
      else $error("read after convert started early");
   a_parallel_drive: assert property (
      !serialMode |=> pinOe == '1)
      else $error("parallel bus not driven");
   a_sync_hold: assert property (
      (master && shifting && !mLast) |=> shifting)
      else $error("frame ended early");
   a_lost_read: assert property (
      sLost |=> incompleteReadFlag ##1 (incompleteReadFlag == $past(sLost)))
      else $error("incomplete read not flagged");

   c_master_frame: cover property (master && mLast);
   c_slave_word: cover property (slave && bitCnt_reg == FULL_CNT);
   c_lost_read: cover property (sLost);
endmodule

//--- verif/host_model.sv
// host that clocks results out of the port in slave mode
`timescale 1ns/1ps
module host_model
   import adc_serial_pkg::*;
(
   // clock and control
   input wire logic clk,
   input wire logic go,
   input wire logic inv,
   // serial pins
   input wire logic sdo,
   output logic sclk,
   output logic csN,
   // what was read
   output logic [RESULT_WIDTH-1:0] word,
   output logic chainBit,
   output logic busy
);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      busy = 1'b0;
      word = '0;
      chainBit = 1'b0;
   end

   // clock stands at its idle level outside frames
   always @(posedge go) begin
      busy = 1'b1;
      sclk = inv;
      @(negedge clk);
      csN = 1'b0;
      repeat (3) @(negedge clk);
      for (int i = 0; i < RESULT_WIDTH; i++) begin
         word = {word[RESULT_WIDTH-2:0], sdo};
         sclk = !inv;
         repeat (4) @(negedge clk);
         sclk = inv;
         repeat (4) @(negedge clk);
      end
      chainBit = sdo;
      csN = 1'b1;
      busy = 1'b0;
   end
endmodule

//--- verif/tb.sv
// self-checking bench for the converter result port
`timescale 1ns/1ps
module tb;
   import adc_serial_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic convStart = 1'b0;
   logic convDone = 1'b0;
   logic [15:0] convResult = '0;
   logic portStyleSelect = 1'b0;
   serial_cfg_t serialCfg = '0;
   logic sclkIn;
   logic csAdcN;
   logic [15:0] pinOut;
   logic [15:0] pinOe;
   logic incompleteReadFlag;
   logic go = 1'b0;
   logic [15:0] hostWord;
   logic chainBit;
   logic busy;
   int errors = 0;
   int tests_run = 0;

   always #12.5 clk = ~clk;

   adc_serial_port_config DUT (.clk(clk), .rst(rst), .convStart(convStart),
      .convDone(convDone), .convResult(convResult),
      .portStyleSelect(portStyleSelect), .serialCfg(serialCfg),
      .sclkIn(sclkIn), .csAdcN(csAdcN), .pinOut(pinOut), .pinOe(pinOe),
      .incompleteReadFlag(incompleteReadFlag));

   host_model HOST (.clk(clk), .go(go), .inv(serialCfg.serialClockInvert),
      .sdo(pinOut[8]), .sclk(sclkIn), .csN(csAdcN), .word(hostWord),
      .chainBit(chainBit), .busy(busy));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic done_pulse(input logic [15:0] w);
      @(negedge clk);
      convResult = w;
      convDone = 1'b1;
      @(negedge clk);
      convDone = 1'b0;
   endtask

   task automatic wait_host();
      int n;
      n = 0;
      while (busy && n < 400) begin
         @(negedge clk);
         n++;
      end
      // a host frame that never ends counts as a mismatch
      check(16'(busy), 16'h0);
   endtask

   task automatic give_verdict();
      $display("errors %0d of %0d checks", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // frame length in clk cycles shows whether the divider was used
   task automatic master(input logic pol, input logic inv, input logic rd,
      input logic [1:0] div, input logic [15:0] w, input int cyc);
      logic [15:0] got;
      logic prev;
      logic s;
      int n;
      got = '0;
      prev = 1'b0;
      serialCfg = {1'b0, div, pol, inv, rd};
      repeat (2) @(negedge clk);
      convStart = 1'b1;
      @(negedge clk);
      convStart = 1'b0;
      if (!rd) begin
         repeat (3) @(negedge clk);
         check(16'(pinOut[10]), 16'(pol));
         done_pulse(w);
      end
      n = 0;
      while (pinOut[10] !== !pol && n < 10) begin
         @(negedge clk);
         n++;
      end
      check(16'(pinOe[10:8]), 16'h7);
      n = 0;
      while (pinOut[10] === !pol && n < 600) begin
         s = pinOut[9] ^ inv;
         if (s && !prev) begin
            got = {got[14:0], pinOut[8]};
         end
         prev = s;
         n++;
         @(negedge clk);
      end
      check(got, w);
      check(16'(n), 16'(cyc));
      check(16'(pinOut[9]), 16'(inv));
   endtask

   task automatic slave(input logic inv, input logic chain,
      input logic [15:0] w);
      serialCfg = {1'b1, 2'h3, 1'b0, inv, chain};
      done_pulse(w);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      check(16'(pinOe[11:8]), 16'h9);
      wait_host();
      check(hostWord, w);
      check(16'(chainBit), 16'(chain));
   endtask

   task automatic cut_read();
      int n;
      serialCfg = {1'b1, 2'h0, 1'b0, 1'b0, 1'b0};
      done_pulse(16'h5a0f);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      repeat (20) @(negedge clk);
      done_pulse(16'h1234);
      n = 0;
      while (incompleteReadFlag !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      check(16'(pinOut[11]), 16'h1);
      @(negedge clk);
      check(16'(incompleteReadFlag), 16'h0);
      wait_host();
      // three bits of the dropped word went out, then the new word from MSB
      check(16'(hostWord[12:0]), 16'(16'h1234 >> 3));
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk);
      check(pinOut, 16'h0);
      rst = 1'b0;
      done_pulse(16'ha5c3);
      repeat (2) @(negedge clk);
      check(pinOut, 16'ha5c3);
      check(pinOe, 16'hffff);
      portStyleSelect = 1'b1;
      master(1'b0, 1'b0, 1'b0, 2'h0, 16'hb38d, 64);
      check(16'(pinOe[7:0]), 16'h0);
      master(1'b1, 1'b1, 1'b0, 2'h2, 16'h4c71, 256);
      master(1'b0, 1'b0, 1'b1, 2'h3, 16'h4c71, 64);
      slave(1'b0, 1'b1, 16'he619);
      slave(1'b1, 1'b0, 16'h27d4);
      cut_read();
      give_verdict();
   end

   // the run needs about 820 cycles
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule
